// File: common/usbcfg_defines.vh
// Constants for the USB link configuration and transfer status block
// Assumes inclusion by bare name from the rtl files
`ifndef USBCFG_DEFINES_VH
`define USBCFG_DEFINES_VH
// ==========================================
// Register offsets (byte addresses)
`define UCX_OFF_CFG 8'h00
`define UCX_OFF_CTRL 8'h04
`define UCX_OFF_STAT 8'h08
`define UCX_OFF_FLAG 8'h0C
// ==========================================
// Configuration fields
`define UCX_CFG_EYE 7
`define UCX_CFG_MON 6
`define UCX_CFG_PUP 4
`define UCX_CFG_XDIS 3
`define UCX_CFG_FS 2
`define UCX_CFG_PPB_HI 1
`define UCX_CFG_PPB_LO 0
`define UCX_CFG_WMASK 8'hDF
`define UCX_CFG_RESET 8'h00
// ==========================================
// Control fields
`define UCX_CTRL_EN 3
`define UCX_CTRL_RESET 8'h00
// ==========================================
// Status entry fields
`define UCX_ST_EP_HI 6
`define UCX_ST_EP_LO 3
`define UCX_ST_DIR 2
`define UCX_ST_BANK 1
`define UCX_FIFO_DEPTH 4
// ==========================================
// Timing
`define UCX_CLK_MHZ 250
`define UCX_FS_MHZ 48
`define UCX_LS_MHZ 6
`define UCX_BIT_FS (`UCX_CLK_MHZ / `UCX_FS_MHZ)
`define UCX_BIT_LS (`UCX_CLK_MHZ / `UCX_LS_MHZ)
`endif

// File: rtl/usbcfg_sync.v
// Two flip-flop synchroniser for one asynchronous level
// Assumes a single clock domain on clk_i
module usbcfg_sync (
  input wire clk_i,
  input wire rst_i,
  input wire d_i,
  output wire q_o
);
  reg s1_q;
  reg s2_q;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end
    else
    begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end
  assign q_o = s2_q;
endmodule

// File: rtl/usbcfg_stfifo.v
// Four-entry transfer status FIFO
// Assumes pushes come from the engine, pops from the flag clear
`include "usbcfg_defines.vh"
module usbcfg_stfifo (
  input wire clk_i,
  input wire rst_i,
  input wire push_i,
  input wire [6:0] data_i,
  input wire pop_i,
  output wire [6:0] data_o,
  output wire empty_o,
  output wire full_o
);
  reg [6:0] mem_q [0:3];
  reg [1:0] rd_q;
  reg [1:0] wr_q;
  reg [2:0] cnt_q;
  wire do_pop;
  wire do_push;
  assign empty_o = (cnt_q == 3'd0);
  assign full_o = (cnt_q == 3'd4);
  assign do_pop = pop_i && !empty_o;
  assign do_push = push_i && (!full_o || do_pop);
  assign data_o = mem_q[rd_q];
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_q <= 2'd0;
      wr_q <= 2'd0;
      cnt_q <= 3'd0;
    end
    else
    begin
      if (do_push)
      begin
        mem_q[wr_q] <= data_i;
        wr_q <= wr_q + 2'd1;
      end
      if (do_pop)
        rd_q <= rd_q + 2'd1;
      if (do_push && !do_pop)
        cnt_q <= cnt_q + 3'd1;
      else if (do_pop && !do_push)
        cnt_q <= cnt_q - 3'd1;
    end
  end
endmodule

// File: rtl/usbcfg_top.v
// USB link configuration, external transceiver interface, status FIFO
// Assumes classic Wishbone master on clk_i; transceiver pins asynchronous
// Operation
// - Bit 7 of configuration enables eye-pattern test
// - Drive monitor bit makes active-low drive enable mark driving intervals
// - Internal transceiver disabled: drive enable works regardless of monitor bit
// - Pull-up on D+ at full speed, D- at low; only with internal transceiver
// - Disable bit routes bus through external transceiver interface
// - Speed bit selects 48 MHz full-speed or 6 MHz low-speed timing
// - Ping-pong field: 00 off, 01 EP0 OUT, 10 all, 11 reserved
// - Bit 5 of configuration reads zero
// - Line drives encode SE0, diff 0, diff 1; both high never driven
// - Line senses decode SE0, low speed, full speed, error
// - Drive enable low makes transceiver transmit engine data, or the eye pattern during eye test
// - Eye test repeats J-K (K-J at full speed) until cleared
// - Status port reads a four-entry FIFO of endpoint, direction, bank
// - Completed transfers push status behind unserviced ones; lost when FIFO full and no pop in that cycle
// - Clearing done flag pops; flag reasserts if entries remain
// - Host request with FIFO full is answered with NACK
// - Entry: endpoint bits 6-3, direction bit 2, bank bit 1
// - Module enable activates engine; cleared, other bits ignored
`include "usbcfg_defines.vh"
module usbcfg_top (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  output wire wb_err_o,
  input wire plus_line_sense_i,
  input wire minus_line_sense_i,
  input wire diff_receive_in_i,
  output reg plus_drive_out_o,
  output reg minus_drive_out_o,
  output reg drive_enable_n_o,
  output reg pullup_dplus_o,
  output reg pullup_dminus_o,
  output reg internal_xcvr_on_o,
  output reg full_speed_edges_o,
  output reg [1:0] pingpong_mode_o,
  output reg engine_bit_tick_o,
  output reg [1:0] line_state_o,
  output wire rx_data_o,
  input wire tx_active_i,
  input wire tx_plus_i,
  input wire tx_minus_i,
  input wire xfer_done_i,
  input wire [3:0] xfer_ep_i,
  input wire xfer_dir_i,
  input wire xfer_bank_i,
  input wire host_request_i,
  output reg nack_auto_o
);
  // ==========================================
  // Line state codes
  localparam [1:0] LS_SE0 = 2'b00;
  localparam [1:0] LS_LOW = 2'b01;
  localparam [1:0] LS_FULL = 2'b10;
  localparam [1:0] LS_ERR = 2'b11;
  // Eye test states, one-hot
  localparam [2:0] EY_IDLE = 3'b001;
  localparam [2:0] EY_J = 3'b010;
  localparam [2:0] EY_K = 3'b100;

  reg [7:0] cfg_q;
  reg [7:0] ctrl_q;
  reg done_q;
  reg ack_q;
  reg [2:0] eye_q;
  reg [2:0] eye_d;
  reg [7:0] div_q;
  wire vp_s;
  wire vm_s;
  wire rcv_s;
  wire en;
  wire xdis;
  wire fs;
  wire eye_on;
  wire [6:0] fifo_q;
  wire fifo_empty;
  wire fifo_full;
  wire req;
  wire wr;
  wire pop;
  wire [31:0] div_fs_full;
  wire [31:0] div_ls_full;
  wire [7:0] div_max;
  wire tick;

  function [1:0] decode_lines;
    input p;
    input m;
    begin
      case ({p, m})
        2'b00: decode_lines = LS_SE0;
        2'b01: decode_lines = LS_LOW;
        2'b10: decode_lines = LS_FULL;
        default: decode_lines = LS_ERR;
      endcase
    end
  endfunction

  // ==========================================
  // Pin synchronisers
  usbcfg_sync u_sync_vp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(plus_line_sense_i),
    .q_o(vp_s)
  );
  usbcfg_sync u_sync_vm (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(minus_line_sense_i),
    .q_o(vm_s)
  );
  usbcfg_sync u_sync_rcv (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(diff_receive_in_i),
    .q_o(rcv_s)
  );

  // ==========================================
  // Wishbone slave, one wait state
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign wb_ack_o = ack_q;
  assign wb_err_o = 1'b0;

  always @(posedge clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= req;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (req)
    begin
      case (wb_adr_i)
        `UCX_OFF_CFG: wb_dat_o <= {24'h00_0000, cfg_q & `UCX_CFG_WMASK};
        `UCX_OFF_CTRL: wb_dat_o <= {24'h00_0000, ctrl_q};
        `UCX_OFF_STAT: wb_dat_o <= {24'h00_0000, 1'b0, fifo_q};
        `UCX_OFF_FLAG: wb_dat_o <= {29'h0000_0000, fifo_full, !fifo_empty, done_q};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Config and control registers
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_q <= `UCX_CFG_RESET;
      ctrl_q <= `UCX_CTRL_RESET;
    end
    else if (wr && !ack_q)
    begin
      if (wb_adr_i == `UCX_OFF_CFG)
        cfg_q <= wb_dat_i[7:0] & `UCX_CFG_WMASK;
      if (wb_adr_i == `UCX_OFF_CTRL)
        ctrl_q <= wb_dat_i[7:0] & 8'h08;
    end
  end

  assign en = ctrl_q[`UCX_CTRL_EN];
  assign xdis = cfg_q[`UCX_CFG_XDIS];
  assign fs = cfg_q[`UCX_CFG_FS];
  assign eye_on = en && cfg_q[`UCX_CFG_EYE];

  // ==========================================
  // Status FIFO and done flag
  // Writing 1 to flag bit 0 clears it and pops
  assign pop = wr && (wb_adr_i == `UCX_OFF_FLAG) && wb_dat_i[0] && done_q;

  usbcfg_stfifo u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .push_i(en && xfer_done_i),
    .data_i({xfer_ep_i, xfer_dir_i, xfer_bank_i, 1'b0}),
    .pop_i(pop),
    .data_o(fifo_q),
    .empty_o(fifo_empty),
    .full_o(fifo_full)
  );

  // Flag follows FIFO occupancy; reasserts after pop if entries remain
  always @(posedge clk_i)
  begin
    if (rst_i)
      done_q <= 1'b0;
    else if (pop)
      done_q <= 1'b0;
    else
      done_q <= !fifo_empty;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      nack_auto_o <= 1'b0;
    else
      nack_auto_o <= en && host_request_i && fifo_full;
  end

  // ==========================================
  // Engine bit-rate divider
  assign div_fs_full = `UCX_BIT_FS - 1;
  assign div_ls_full = `UCX_BIT_LS - 1;
  assign div_max = fs ? div_fs_full[7:0] : div_ls_full[7:0];
  assign tick = (div_q == div_max);

  always @(posedge clk_i)
  begin
    if (rst_i || !en)
      div_q <= 8'h00;
    else if (tick)
      div_q <= 8'h00;
    else
      div_q <= div_q + 8'h01;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      engine_bit_tick_o <= 1'b0;
    else
      engine_bit_tick_o <= en && tick;
  end

  // ==========================================
  // Eye pattern state machine
  always @*
  begin
    eye_d = eye_q;
    case (eye_q)
      EY_IDLE:
      begin
        if (eye_on && tick)
          eye_d = fs ? EY_K : EY_J;
      end
      EY_J:
      begin
        if (!eye_on)
          eye_d = EY_IDLE;
        else if (tick)
          eye_d = EY_K;
      end
      EY_K:
      begin
        if (!eye_on)
          eye_d = EY_IDLE;
        else if (tick)
          eye_d = EY_J;
      end
      default: eye_d = EY_IDLE;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      eye_q <= EY_IDLE;
    else
      eye_q <= eye_d;
  end

  // ==========================================
  // Transceiver drive
  // J is diff 1 at full speed, diff 0 at low speed
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      plus_drive_out_o <= 1'b0;
      minus_drive_out_o <= 1'b0;
      drive_enable_n_o <= 1'b1;
    end
    else if (en && eye_q != EY_IDLE)
    begin
      plus_drive_out_o <= (eye_q == EY_J) ? fs : !fs;
      minus_drive_out_o <= (eye_q == EY_J) ? !fs : fs;
      drive_enable_n_o <= !(xdis || cfg_q[`UCX_CFG_MON]);
    end
    else if (en && tx_active_i)
    begin
      plus_drive_out_o <= tx_plus_i;
      minus_drive_out_o <= tx_minus_i && !tx_plus_i;
      drive_enable_n_o <= !(xdis || cfg_q[`UCX_CFG_MON]);
    end
    else
    begin
      plus_drive_out_o <= 1'b0;
      minus_drive_out_o <= 1'b0;
      drive_enable_n_o <= 1'b1;
    end
  end

  // ==========================================
  // Configuration outputs and line sense
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pullup_dplus_o <= 1'b0;
      pullup_dminus_o <= 1'b0;
      internal_xcvr_on_o <= 1'b0;
      full_speed_edges_o <= 1'b0;
      pingpong_mode_o <= 2'b00;
      line_state_o <= LS_SE0;
    end
    else
    begin
      pullup_dplus_o <= en && !xdis && cfg_q[`UCX_CFG_PUP] && fs;
      pullup_dminus_o <= en && !xdis && cfg_q[`UCX_CFG_PUP] && !fs;
      internal_xcvr_on_o <= en && !xdis;
      full_speed_edges_o <= en && fs;
      pingpong_mode_o <= en ? cfg_q[`UCX_CFG_PPB_HI:`UCX_CFG_PPB_LO] : 2'b00;
      line_state_o <= en ? decode_lines(vp_s, vm_s) : LS_SE0;
    end
  end

  assign rx_data_o = en && rcv_s;
endmodule

// File: verification/usbcfg_chk.sv
// Checker for the configuration, transceiver and status block
// Assumes binding onto usbcfg_top, one clock, synchronous reset
module usbcfg_chk (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire plus_line_sense_i,
  input wire minus_line_sense_i,
  input wire plus_drive_out_o,
  input wire minus_drive_out_o,
  input wire drive_enable_n_o,
  input wire pullup_dplus_o,
  input wire pullup_dminus_o,
  input wire internal_xcvr_on_o,
  input wire full_speed_edges_o,
  input wire engine_bit_tick_o,
  input wire [1:0] line_state_o,
  input wire host_request_i,
  input wire nack_auto_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ========
  // Properties
  drive_excl_a: assert property (!(plus_drive_out_o && minus_drive_out_o))
    else $error("both line drives high");
  pup_plus_a: assert property (pullup_dplus_o |-> full_speed_edges_o && internal_xcvr_on_o)
    else $error("plus pull-up in wrong mode");
  pup_minus_a: assert property (pullup_dminus_o |-> !full_speed_edges_o && internal_xcvr_on_o)
    else $error("minus pull-up in wrong mode");
  nack_cause_a: assert property (nack_auto_o |-> $past(host_request_i))
    else $error("nack without request");
  tick_pulse_a: assert property (engine_bit_tick_o |=> !engine_bit_tick_o)
    else $error("bit tick longer than one cycle");
  ls_plus_a: assert property (line_state_o[1] |-> $past(plus_line_sense_i, 3))
    else $error("plus line state without sense");
  ls_minus_a: assert property (line_state_o[0] |-> $past(minus_line_sense_i, 3))
    else $error("minus line state without sense");
  ack_take_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  cover property (nack_auto_o);
  cover property (!drive_enable_n_o);
  cover property (pullup_dminus_o);
endmodule
bind usbcfg_top usbcfg_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .plus_line_sense_i, .minus_line_sense_i, .plus_drive_out_o, .minus_drive_out_o,
  .drive_enable_n_o, .pullup_dplus_o, .pullup_dminus_o, .internal_xcvr_on_o,
  .full_speed_edges_o, .engine_bit_tick_o, .line_state_o, .host_request_i, .nack_auto_o);

// File: verification/usbcfg_xcvr_model.sv
// External transceiver stand-in on the link pins
// Assumes the bench supplies the far bus state; one clock
module usbcfg_xcvr_model (
  input wire clk_i,
  input wire plus_drive_out_i,
  input wire minus_drive_out_i,
  input wire drive_enable_n_i,
  input wire [1:0] bus_state_i,
  output logic plus_line_sense_o = 1'b1,
  output logic minus_line_sense_o = 1'b0,
  output logic diff_receive_in_o = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========
  // Device owns the bus while enabled, else far side
  always @(posedge clk_i)
  begin
    plus_line_sense_o <= drive_enable_n_i ? bus_state_i[1] : plus_drive_out_i;
    minus_line_sense_o <= drive_enable_n_i ? bus_state_i[0] : minus_drive_out_i;
  end
  // Pulse train follows D+, toggles on single-ended states
  always @(posedge clk_i)
    diff_receive_in_o <= (plus_line_sense_o ^ minus_line_sense_o) ? plus_line_sense_o
                         : ~diff_receive_in_o;
endmodule

// File: verification/usb_sie_config_xcvr_status_bench.sv
// Self-checking bench for the link configuration block
// Assumes usbcfg_top, checker bound, transceiver model beside it
`include "usbcfg_defines.vh"
module usb_sie_config_xcvr_status_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc = 0, stb = 0, we = 0, ta = 0, tp = 0, tm = 0;
  logic xd = 0, xr = 0, xb = 0, hr = 0;
  logic [7:0] adr = 0;
  logic [31:0] wd = 0, q;
  logic [3:0] xe = 0;
  logic [3:0] sel = 4'h1;
  logic [1:0] hs = 2'h2;
  wire [31:0] rd;
  wire [1:0] pp, ls;
  wire ack, ps, ms, diff_receive_in, po, mo, oen, pud, pum, xon, fse, nk, tk, rx;
  int n_fail = 0, checks = 0, cyc_n = 0;
  always #2 clk_i = ~clk_i;
  usbcfg_top u_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
    .wb_err_o(), .plus_line_sense_i(ps), .minus_line_sense_i(ms), .diff_receive_in_i(diff_receive_in),
    .plus_drive_out_o(po), .minus_drive_out_o(mo), .drive_enable_n_o(oen),
    .pullup_dplus_o(pud), .pullup_dminus_o(pum), .internal_xcvr_on_o(xon),
    .full_speed_edges_o(fse), .pingpong_mode_o(pp), .engine_bit_tick_o(tk),
    .line_state_o(ls), .rx_data_o(rx), .tx_active_i(ta), .tx_plus_i(tp), .tx_minus_i(tm),
    .xfer_done_i(xd), .xfer_ep_i(xe), .xfer_dir_i(xr), .xfer_bank_i(xb),
    .host_request_i(hr), .nack_auto_o(nk));
  usbcfg_xcvr_model u_xcvr (.clk_i, .plus_drive_out_i(po), .minus_drive_out_i(mo),
    .drive_enable_n_i(oen), .bus_state_i(hs), .plus_line_sense_o(ps),
    .minus_line_sense_o(ms), .diff_receive_in_o(diff_receive_in));
  // ========
  // Hang guard and verdict
  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 30000)
    begin
      n_fail = n_fail + 1;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // ========
  // Classic Wishbone cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rd;
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdck(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    ck(q, e);
  endtask
  task automatic set_cfg(input logic [7:0] c);
    wr(`UCX_OFF_CTRL, 32'h0000_0000);
    wr(`UCX_OFF_CFG, {24'h00_0000, c});
    wr(`UCX_OFF_CTRL, 32'h0000_0008);
    repeat (3) @(negedge clk_i);
  endtask
  task automatic req(input logic e);
    @(posedge clk_i);
    hr <= 1;
    @(posedge clk_i);
    hr <= 0;
    @(negedge clk_i);
    ck(nk, e);
  endtask
  // ========
  // Scenarios
  task automatic t_regs();
    rdck(`UCX_OFF_CFG, 32'h0000_0000);
    wr(`UCX_OFF_CFG, 32'h0000_00FF);
    rdck(`UCX_OFF_CFG, 32'h0000_00DF);
    sel <= 4'h0;
    wr(`UCX_OFF_CFG, 32'h0000_0000);
    sel <= 4'h1;
    rdck(`UCX_OFF_CFG, 32'h0000_00DF);
    rdck(8'h10, 32'h0000_0000);
  endtask
  task automatic t_cfg();
    for (int i = 0; i < 3; i++)
    begin
      set_cfg(8'h14 | i);
      ck(pp, i);
      ck({pud, pum, xon, fse}, 4'hB);
    end
    set_cfg(8'h10);
    ck({pud, pum, xon, fse}, 4'h6);
    set_cfg(8'h1C);
    ck({pud, pum, xon, fse}, 4'h1);
  endtask
  task automatic t_line();
    set_cfg(8'h04);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_i);
      hs <= i;
      repeat (5) @(negedge clk_i);
      ck(ls, i);
      if (i == 1 || i == 2) ck(rx, i / 2);
    end
    hs <= 2'h2;
  endtask
  task automatic t_eye(input logic [7:0] c, input logic oe, input int per);
    logic [1:0] s;
    int n;
    set_cfg(c);
    while ({po, mo} === 2'h0) @(negedge clk_i);
    s = {po, mo};
    ck(s, 2'h1);
    ck(oen, oe);
    while ({po, mo} === s) @(negedge clk_i);
    s = {po, mo};
    ck(s, 2'h2);
    n = 0;
    while ({po, mo} === s && n < 100)
    begin
      @(negedge clk_i);
      n++;
    end
    ck(n, per);
    while (tk !== 1'b1) @(negedge clk_i);
    n = 1;
    @(negedge clk_i);
    while (tk !== 1'b1 && n < 100)
    begin
      @(negedge clk_i);
      n++;
    end
    ck(n, per);
    wr(`UCX_OFF_CFG, {25'h000_0000, c[6:0]});
    repeat (4) @(negedge clk_i);
    ck(oen, 1'b1);
  endtask
  task automatic t_tx();
    set_cfg(8'h0C);
    @(posedge clk_i);
    ta <= 1;
    tp <= 1;
    repeat (4) @(negedge clk_i);
    ck({oen, po, mo}, 3'h2);
    @(posedge clk_i);
    tp <= 0;
    tm <= 1;
    repeat (4) @(negedge clk_i);
    ck({oen, po, mo}, 3'h1);
    @(posedge clk_i);
    ta <= 0;
    tm <= 0;
    repeat (4) @(negedge clk_i);
    ck(oen, 1'b1);
  endtask
  task automatic t_fifo();
    set_cfg(8'h04);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk_i);
      xd <= 1;
      xe <= 4'(3 * i + 1);
      xr <= i[0];
      xb <= ~i[0];
    end
    @(posedge clk_i);
    xd <= 0;
    rdck(`UCX_OFF_FLAG, 32'h0000_0007);
    req(1'b1);
    for (int i = 0; i < 4; i++)
    begin
      rdck(`UCX_OFF_STAT, {25'h0, 4'(3 * i + 1), i[0], ~i[0], 1'b0});
      wr(`UCX_OFF_FLAG, 32'h0000_0001);
    end
    rdck(`UCX_OFF_FLAG, 32'h0000_0000);
    req(1'b0);
  endtask
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    t_regs();
    t_cfg();
    t_line();
    t_eye(8'hC4, 1'b0, `UCX_BIT_FS);
    t_eye(8'h80, 1'b1, `UCX_BIT_LS);
    t_eye(8'h88, 1'b0, `UCX_BIT_LS);
    t_tx();
    t_fifo();
    close_out();
  end
endmodule
